// *** pkg/hot_pkg.sv ***
// Purpose: Shared constants and types for the HDLC overhead transmit path
// Assumes: Wishbone register side on core_clk, serial side on the line clock
// Notes: Offsets are byte addresses of aligned 32-bit words
`default_nettype none
package hot_pkg;
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] DATA_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  // Control fields
  localparam int CTRL_CFG_LSB = 0;
  localparam int CTRL_THRESH_LSB = 8;
  localparam logic [5:0] CTRL_CFG_RESET = 6'h00;
  localparam logic [7:0] THRESH_RESET = 8'h10;
  // Data fields
  localparam int DATA_EOP_BIT = 8;
  // Status fields
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_AVAIL_BIT = 1;
  localparam int STAT_FULL_BIT = 2;
  localparam int STAT_OVF_BIT = 3;
  localparam int STAT_UNF_BIT = 4;
  localparam int STAT_LEVEL_LSB = 16;
  // FIFO and framing figures
  localparam int FIFO_DEPTH = 256;
  localparam int START_MIN_BYTES = 2;
  localparam logic [3:0] ONES_MIN = 4'hf;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [7:0] FLAG_OCTET = 8'h7e;
  localparam logic [7:0] ABORT_OCTET = 8'hff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Software configuration carried as one word
  typedef struct packed {
    logic packetStart;
    logic invertOut;
    logic onesFill;
    logic bitReorder;
    logic fcsErrInsert;
    logic fcsEnable;
  } hot_cfg_t;

  typedef enum logic [2:0] {TX_FILL, TX_DATA, TX_FCS, TX_END} hot_tx_state_t;
endpackage
`default_nettype wire

// *** rtl/hot_sync.sv ***
// Purpose: Two-flop level synchroniser for a bus of bits
// Assumes: Source bits change in Gray or quasi-static fashion
// Notes: First stage feeds only the second stage
`default_nettype none
module hot_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;

  // Two stage resolve
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      stage1 <= '0;
      q <= '0;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule // hot_sync
`default_nettype wire

// *** rtl/hot_tx_path.sv ***
// Purpose: HDLC overhead transmit FIFO and serial packet processor
// Assumes: lineBitEnable pulses at most once every two lineClk cycles
// Notes: Host side on core_clk, serial side on lineClk, Gray pointers between
`default_nettype none
module hot_tx_path #(
  parameter int DEPTH = hot_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic lineClk,
  input wire logic lineBitEnable,
  output logic lineBitOut
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
  localparam logic [AW:0] START_W = (AW+1)'(hot_pkg::START_MIN_BYTES);
  // Local names for the sequencer states
  localparam hot_pkg::hot_tx_state_t TX_FILL = hot_pkg::TX_FILL;
  localparam hot_pkg::hot_tx_state_t TX_DATA = hot_pkg::TX_DATA;
  localparam hot_pkg::hot_tx_state_t TX_FCS = hot_pkg::TX_FCS;
  localparam hot_pkg::hot_tx_state_t TX_END = hot_pkg::TX_END;

  // Mirror a byte end for end
  function automatic logic [7:0] revByte(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = v[7-i];
    return r;
  endfunction

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    for (int i = AW; i >= 0; i--)
      b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
    return b;
  endfunction

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? hot_pkg::CRC_POLY : 16'h0000);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host side
  logic [8:0] memory [DEPTH];
  hot_pkg::hot_cfg_t cfg;
  logic [7:0] threshold;
  logic [AW:0] wrPtr;
  logic [AW:0] wrGray;
  logic [AW:0] rdGraySync;
  logic [AW:0] rdGrayLine;
  logic unfToggle;
  logic [AW:0] coreLevel;
  logic fifoEmpty;
  logic fifoAvail;
  logic fifoFull;
  logic overflow;
  logic underflow;
  logic unfToggleSync;
  logic unfTogglePrev;
  logic unfEvent;
  logic busReq;
  logic busWrite;
  logic dataPush;
  logic pushBlocked;

  assign busReq = cyc_i & stb_i & ~ack_o;
  assign busWrite = busReq & we_i;
  assign dataPush = busWrite & (adr_i == hot_pkg::DATA_OFFSET) & sel_i[0];
  assign pushBlocked = dataPush & fifoFull;
  assign coreLevel = wrPtr - gray2bin(rdGraySync);
  // Fill states
  assign fifoEmpty = (coreLevel == '0);
  assign fifoFull = (coreLevel == DEPTH_W);
  assign fifoAvail = ((DEPTH_W - coreLevel) >= (AW+1)'(threshold));
  assign unfEvent = unfToggleSync ^ unfTogglePrev;

  // Read pointer into host domain
  hot_sync #(.W(AW+1)) rdPtrSync (
    .clk(core_clk),
    .reset(reset),
    .d(rdGrayLine),
    .q(rdGraySync)
  );

  // Underflow toggle into host domain
  hot_sync #(.W(1)) unfSync (
    .clk(core_clk),
    .reset(reset),
    .d(unfToggle),
    .q(unfToggleSync)
  );

  // Bus acknowledge, one cycle after request
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      ack_o <= 1'b0;
    else
      ack_o <= busReq;
  end

  // Read data mux, unmapped reads return zero
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      dat_o <= 32'h00000000;
    else if (busReq & ~we_i)
    begin
      dat_o <= 32'h00000000;
      unique case (adr_i)
        hot_pkg::CTRL_OFFSET:
        begin
          dat_o[hot_pkg::CTRL_CFG_LSB +: 6] <= cfg;
          dat_o[hot_pkg::CTRL_THRESH_LSB +: 8] <= threshold;
        end
        hot_pkg::STATUS_OFFSET:
        begin
          dat_o[hot_pkg::STAT_EMPTY_BIT] <= fifoEmpty;
          dat_o[hot_pkg::STAT_AVAIL_BIT] <= fifoAvail;
          dat_o[hot_pkg::STAT_FULL_BIT] <= fifoFull;
          dat_o[hot_pkg::STAT_OVF_BIT] <= overflow;
          dat_o[hot_pkg::STAT_UNF_BIT] <= underflow;
          dat_o[hot_pkg::STAT_LEVEL_LSB +: AW+1] <= coreLevel;
        end
        default:
          dat_o <= 32'h00000000;
      endcase
    end
  end

  // Control register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg <= hot_pkg::CTRL_CFG_RESET;
      threshold <= hot_pkg::THRESH_RESET;
    end
    else if (busWrite & (adr_i == hot_pkg::CTRL_OFFSET))
    begin
      if (sel_i[0])
        cfg <= dat_i[hot_pkg::CTRL_CFG_LSB +: 6];
      if (sel_i[1])
        threshold <= dat_i[hot_pkg::CTRL_THRESH_LSB +: 8];
    end
  end

  // FIFO write side
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wrPtr <= '0;
      wrGray <= '0;
    end
    else if (dataPush & ~fifoFull)
    begin
      wrPtr <= wrPtr + 1'b1;
      wrGray <= (wrPtr + 1'b1) ^ ((wrPtr + 1'b1) >> 1);
    end
  end

  // Storage, no reset
  always_ff @(posedge core_clk)
  begin
    if (dataPush & ~fifoFull)
      memory[wrPtr[AW-1:0]] <= {dat_i[hot_pkg::DATA_EOP_BIT] & sel_i[1], dat_i[7:0]};
  end

  // Sticky status, set wins over write-one clear
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      overflow <= 1'b0;
      underflow <= 1'b0;
      unfTogglePrev <= 1'b0;
    end
    else
    begin
      unfTogglePrev <= unfToggleSync;
      if (pushBlocked)
        overflow <= 1'b1;
      else if (busWrite & (adr_i == hot_pkg::STATUS_OFFSET) & sel_i[0] & dat_i[hot_pkg::STAT_OVF_BIT])
        overflow <= 1'b0;
      if (unfEvent)
        underflow <= 1'b1;
      else if (busWrite & (adr_i == hot_pkg::STATUS_OFFSET) & sel_i[0] & dat_i[hot_pkg::STAT_UNF_BIT])
        underflow <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line side
  hot_pkg::hot_cfg_t lineCfg;
  hot_pkg::hot_tx_state_t state;
  logic [AW:0] rdPtr;
  logic [AW:0] wrGraySync;
  logic [AW:0] lineLevel;
  logic lineEmpty;
  logic startable;
  logic [7:0] shReg;
  logic [3:0] shCnt;
  logic shStuff;
  logic [2:0] onesRun;
  logic [3:0] onesCnt;
  logic fcsIdx;
  logic [15:0] crc;
  logic [15:0] fcsVal;
  logic [8:0] rdWord;
  logic [7:0] orderedByte;
  logic stuffPending;
  logic loadNow;
  logic fetchEmpty;

  hot_sync #(.W(AW+1)) wrPtrSync (
    .clk(lineClk),
    .reset(reset),
    .d(wrGray),
    .q(wrGraySync)
  );

  hot_sync #(.W(6)) cfgSync (
    .clk(lineClk),
    .reset(reset),
    .d(cfg),
    .q(lineCfg)
  );

  assign lineLevel = gray2bin(wrGraySync) - rdPtr;
  assign lineEmpty = (lineLevel == '0);
  assign startable = (lineLevel >= START_W) & lineCfg.packetStart;
  assign rdWord = memory[rdPtr[AW-1:0]];
  // Bit order into the serial register
  assign orderedByte = lineCfg.bitReorder ? revByte(rdWord[7:0]) : rdWord[7:0];
  assign fcsVal = lineCfg.fcsErrInsert ? crc : ~crc;
  assign stuffPending = shStuff & (onesRun == hot_pkg::STUFF_RUN);
  assign loadNow = (shCnt == 4'h0) & ~stuffPending;
  assign fetchEmpty = loadNow & (state == TX_DATA) & lineEmpty;

  // Unit loader and packet sequencing
  always_ff @(posedge lineClk or posedge reset)
  begin
    if (reset)
    begin
      state <= TX_FILL;
      shReg <= 8'h00;
      shCnt <= 4'h0;
      shStuff <= 1'b0;
      onesCnt <= 4'h0;
      fcsIdx <= 1'b0;
      crc <= hot_pkg::CRC_INIT;
      rdPtr <= '0;
      rdGrayLine <= '0;
    end
    else if (loadNow)
    begin
      unique case (state)
        TX_FILL:
        begin
          if (startable & (~lineCfg.onesFill | (onesCnt == 4'h0) | (onesCnt == hot_pkg::ONES_MIN)))
          begin
            shReg <= hot_pkg::FLAG_OCTET;
            shCnt <= hot_pkg::BITS_PER_BYTE;
            shStuff <= 1'b0;
            crc <= hot_pkg::CRC_INIT;
            state <= TX_DATA;
          end
          else if (lineCfg.onesFill)
          begin
            shReg <= hot_pkg::ABORT_OCTET;
            shCnt <= 4'h1;
            shStuff <= 1'b0;
            if (onesCnt != hot_pkg::ONES_MIN)
              onesCnt <= onesCnt + 4'h1;
          end
          else
          begin
            shReg <= hot_pkg::FLAG_OCTET;
            shCnt <= hot_pkg::BITS_PER_BYTE;
            shStuff <= 1'b0;
          end
        end
        TX_DATA:
        begin
          if (lineEmpty)
          begin
            shReg <= hot_pkg::ABORT_OCTET;
            shCnt <= hot_pkg::BITS_PER_BYTE;
            shStuff <= 1'b0;
            onesCnt <= 4'h0;
            state <= TX_FILL;
          end
          else
          begin
            shReg <= orderedByte;
            shCnt <= hot_pkg::BITS_PER_BYTE;
            shStuff <= 1'b1;
            crc <= crcByte(crc, orderedByte);
            rdPtr <= rdPtr + 1'b1;
            rdGrayLine <= (rdPtr + 1'b1) ^ ((rdPtr + 1'b1) >> 1);
            fcsIdx <= 1'b0;
            if (rdWord[8])
              state <= lineCfg.fcsEnable ? TX_FCS : TX_END;
          end
        end
        TX_FCS:
        begin
          shReg <= fcsIdx ? revByte(fcsVal[7:0]) : revByte(fcsVal[15:8]);
          shCnt <= hot_pkg::BITS_PER_BYTE;
          shStuff <= 1'b1;
          fcsIdx <= ~fcsIdx;
          if (fcsIdx)
            state <= TX_END;
        end
        TX_END:
        begin
          shReg <= hot_pkg::FLAG_OCTET;
          shCnt <= hot_pkg::BITS_PER_BYTE;
          shStuff <= 1'b0;
          onesCnt <= 4'h0;
          state <= TX_FILL;
        end
      endcase
    end
    else if (lineBitEnable & ~stuffPending & (shCnt != 4'h0))
    begin
      shReg <= {1'b0, shReg[7:1]};
      shCnt <= shCnt - 4'h1;
    end
  end

  // Run of ones for stuffing
  always_ff @(posedge lineClk or posedge reset)
  begin
    if (reset)
      onesRun <= 3'h0;
    else if (lineBitEnable & (stuffPending | (shCnt != 4'h0)))
    begin
      if (stuffPending | ~shStuff | ~shReg[0])
        onesRun <= 3'h0;
      else
        onesRun <= onesRun + 3'h1;
    end
  end

  // Serial output with optional inversion
  always_ff @(posedge lineClk or posedge reset)
  begin
    if (reset)
      lineBitOut <= 1'b1;
    else if (lineBitEnable & stuffPending)
      lineBitOut <= lineCfg.invertOut;
    else if (lineBitEnable & (shCnt != 4'h0))
      lineBitOut <= shReg[0] ^ lineCfg.invertOut;
  end

  // Underflow event toggle
  always_ff @(posedge lineClk or posedge reset)
  begin
    if (reset)
      unfToggle <= 1'b0;
    else if (fetchEmpty)
      unfToggle <= ~unfToggle;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence busRequest;
    cyc_i & stb_i & ~ack_o;
  endsequence

  sequence busAnswered;
    ack_o ##1 ~ack_o;
  endsequence

  bus_ack_a: assert property (@(posedge core_clk) disable iff (reset)
    busRequest |=> busAnswered)
    else $error("bus ack not a single cycle after request");

  full_drop_a: assert property (@(posedge core_clk) disable iff (reset)
    pushBlocked |=> $stable(wrPtr) && overflow)
    else $error("write while full changed the FIFO or missed overflow");

  level_bound_a: assert property (@(posedge core_clk) disable iff (reset)
    coreLevel <= DEPTH_W && (fifoFull -> !fifoAvail || threshold == 8'h00))
    else $error("FIFO level out of range");

  unf_report_a: assert property (@(posedge lineClk) disable iff (reset)
    fetchEmpty |=> unfToggle != $past(unfToggle))
    else $error("underflow event not raised");

  abort_load_a: assert property (@(posedge lineClk) disable iff (reset)
    fetchEmpty |=> shReg == hot_pkg::ABORT_OCTET && state == TX_FILL && !shStuff)
    else $error("abort octet not loaded on empty fetch");

  stuff_zero_a: assert property (@(posedge lineClk) disable iff (reset)
    lineBitEnable && stuffPending |=> lineBitOut == lineCfg.invertOut && onesRun == 3'h0)
    else $error("stuffed zero missing");

  fcs_skip_a: assert property (@(posedge lineClk) disable iff (reset)
    loadNow && state == TX_DATA && !lineEmpty && rdWord[8] && !lineCfg.fcsEnable |=> state == TX_END)
    else $error("checksum appended while disabled");

  end_flag_a: assert property (@(posedge lineClk) disable iff (reset)
    loadNow && state == TX_END |=> shReg == hot_pkg::FLAG_OCTET && state == TX_FILL)
    else $error("end flag not 7e");

  start_gate_a: assert property (@(posedge lineClk) disable iff (reset)
    loadNow && state == TX_FILL && !startable |=> state == TX_FILL)
    else $error("packet started without two bytes or start enable");
endmodule // hot_tx_path
`default_nettype wire

// *** verification/hot_line_model.sv ***
// Purpose: Line framer overhead slot model for the transmit path
// Assumes: One bit slot every two lineClk cycles, clock unrelated to core_clk
// Notes: Every captured serial bit is kept in bits for the bench to search
`default_nettype none
module hot_line_model (
  output logic lineClk,
  output logic lineBitEnable,
  input wire logic lineBitOut,
  input wire logic reset
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slotTaken;
  logic bits[$];

  ////////////////////////////////////////////////////////////////////////////
  // Free-running line clock and quiet start
  initial
  begin
    lineClk = 1'b0;
    lineBitEnable = 1'b0;
    slotTaken = 1'b0;
  end
  always #21 lineClk = ~lineClk;

  // Slot pulse every second cycle, bit taken one edge after its slot
  always @(posedge lineClk or posedge reset)
  begin
    if (reset)
    begin
      lineBitEnable <= 1'b0;
      slotTaken <= 1'b0;
    end
    else
    begin
      lineBitEnable <= ~lineBitEnable;
      slotTaken <= lineBitEnable;
      if (slotTaken)
        bits.push_back(lineBitOut);
    end
  end
endmodule // hot_line_model
`default_nettype wire

// *** verification/test_hdlc_overhead_transmit_path.sv ***
// Purpose: Self-checking bench for the HDLC overhead transmit path
// Assumes: Wishbone host on core_clk, line slots from hot_line_model
// Notes: Expected serial streams are built here and searched in the capture
`default_nettype none
module test_hdlc_overhead_transmit_path;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic ack_o;
  logic lineClk;
  logic lineBitEnable;
  logic lineBitOut;
  int failCount = 0;
  int checks = 0;
  int ones;
  logic [15:0] crc;
  logic [31:0] rd;
  logic found;
  logic exp[$];
  logic [5:0] cases[5] = '{6'h21, 6'h23, 6'h24, 6'h29, 6'h31};

  ////////////////////////////////////////////////////////////////////////////
  // Host clock, 50 ns period
  always #25 core_clk = ~core_clk;

  hot_tx_path #(.DEPTH(hot_pkg::FIFO_DEPTH)) dut (
    .core_clk(core_clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .lineClk(lineClk), .lineBitEnable(lineBitEnable), .lineBitOut(lineBitOut)
  );

  hot_line_model line (
    .lineClk(lineClk), .lineBitEnable(lineBitEnable), .lineBitOut(lineBitOut), .reset(reset)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Report and end
  task giveVerdict;
    $display("Counts: %0d checks, %0d mismatches", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Compare one value
  task chk(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want)
    begin
      failCount++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge core_clk);
    while (ack_o !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20)
    begin
      failCount++;
      $display("[ERR] %0t no bus answer", $time);
      giveVerdict();
    end
  endtask

  task rdChk(input logic [7:0] a, input logic [31:0] want);
    wb(1'b0, a, 32'h00000000);
    chk(rd, want);
  endtask

  // Wait until n more line bits are captured
  task waitBits(input int n);
    int lim;
    int k;
    lim = line.bits.size() + n;
    k = 0;
    while (line.bits.size() < lim && k < 20000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 20000)
    begin
      failCount++;
      $display("[ERR] %0t line stalled", $time);
      giveVerdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Expected stream building
  task flag;
    for (int k = 0; k < 8; k++)
      exp.push_back(hot_pkg::FLAG_OCTET[k]);
  endtask

  task onesRaw(input int n);
    for (int k = 0; k < n; k++)
      exp.push_back(1'b1);
  endtask

  task sb(input logic b);
    exp.push_back(b);
    ones = b ? ones + 1 : 0;
    if (ones == 5)
    begin
      exp.push_back(1'b0);
      ones = 0;
    end
  endtask

  // Two bytes, low byte first, then FCS as the config asks
  task pkt(input logic [15:0] two, input logic [5:0] cfg);
    logic b;
    ones = 0;
    crc = 16'hffff;
    for (int i = 0; i < 16; i++)
    begin
      b = cfg[2] ? two[8 * (i / 8) + 7 - i % 8] : two[i];
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? 16'h1021 : 16'h0000);
      sb(b);
    end
    if (cfg[0])
      for (int i = 15; i >= 0; i--)
        sb(crc[i] ^ ~cfg[1]);
  endtask

  task find(output logic f);
    int j;
    f = 1'b0;
    for (int i = 0; i + exp.size() <= line.bits.size() && !f; i++)
    begin
      j = 0;
      while (j < exp.size() && line.bits[i + j] === exp[j])
        j++;
      f = (j == exp.size());
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rdChk(8'h00, 32'h00001000);
    rdChk(8'h08, 32'h00000003);
    rdChk(8'h04, 32'h00000000);
    rdChk(8'h0c, 32'h00000000);
    // Fill with packet start off, so nothing drains
    for (int i = 0; i < 256; i++)
    begin
      wb(1'b1, 8'h04, {24'h000000, i[7:0]});
      if (i == 239)
        rdChk(8'h08, 32'h00f00002);
      if (i == 240)
        rdChk(8'h08, 32'h00f10000);
    end
    rdChk(8'h08, 32'h01000004);
    wb(1'b1, 8'h04, 32'h000000aa);
    rdChk(8'h08, 32'h0100000c);
    wb(1'b1, 8'h08, 32'h00000008);
    rdChk(8'h08, 32'h01000004);
    // Second reset in mid-run
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rdChk(8'h08, 32'h00000003);
    // Two back-to-back packets per configuration
    for (int c = 0; c < 5; c++)
    begin
      wb(1'b1, 8'h00, {16'h0000, 8'h10, 2'b00, cases[c]});
      waitBits(40);
      exp.delete();
      if (cases[c][3])
        onesRaw(15);
      else
        flag();
      flag();
      pkt({8'hff, 8'h10 + c[7:0]}, cases[c]);
      flag();
      flag();
      pkt({8'h80 + c[7:0], 8'h3e}, cases[c]);
      flag();
      if (cases[c][3])
        onesRaw(8);
      else
        flag();
      if (cases[c][4])
        foreach (exp[k])
          exp[k] = ~exp[k];
      wb(1'b1, 8'h04, {24'h000000, 8'h10 + c[7:0]});
      wb(1'b1, 8'h04, 32'h000001ff);
      wb(1'b1, 8'h04, 32'h0000003e);
      wb(1'b1, 8'h04, {23'h000000, 1'b1, 8'h80 + c[7:0]});
      waitBits(exp.size() + 100);
      find(found);
      chk({31'h0, found}, 32'h00000001);
    end
    // Packet left without an end mark runs dry
    wb(1'b1, 8'h00, 32'h00001021);
    waitBits(40);
    exp.delete();
    flag();
    flag();
    pkt(16'h2211, 6'h20);
    onesRaw(8);
    flag();
    wb(1'b1, 8'h04, 32'h00000011);
    wb(1'b1, 8'h04, 32'h00000022);
    waitBits(exp.size() + 100);
    find(found);
    chk({31'h0, found}, 32'h00000001);
    rdChk(8'h08, 32'h00000013);
    wb(1'b1, 8'h08, 32'h00000010);
    rdChk(8'h08, 32'h00000003);
    giveVerdict();
  end
endmodule // test_hdlc_overhead_transmit_path
`default_nettype wire
